// *** rtl/uabw_pkg.sv ***
// shared constants for the auto-baud and wake-on-break receiver block
package uabw_pkg;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STAT     = 8'h04;
  localparam logic [7:0]  ADDR_DIV      = 8'h08;
  localparam logic [7:0]  ADDR_DATA     = 8'h0c;
  // control register bits
  localparam int          CTRL_AB       = 0;
  localparam int          CTRL_WAKE     = 1;
  localparam int          CTRL_WIDE     = 2;
  localparam int          CTRL_HS       = 3;
  localparam int          CTRL_SYNC     = 4;
  localparam int          CTRL_OVF      = 5;
  // status register bits
  localparam int          STAT_FLAG     = 0;
  localparam int          STAT_IDLE     = 1;
  localparam int          STAT_FERR     = 2;
  // reset values
  localparam logic [15:0] DIV_RST       = 16'h0000;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  // prescale ratios from the oscillator to the rate base clock
  localparam logic [6:0]  PRE_SLOW      = 7'h40;
  localparam logic [6:0]  PRE_MID       = 7'h10;
  localparam logic [6:0]  PRE_FAST      = 7'h04;
  // measurement clock runs at this fraction of the base clock
  localparam logic [3:0]  ABD_RATIO     = 4'h8;
  // rising edges in a sync character, and counter start value
  localparam logic [2:0]  SYNC_RISES    = 3'h5;
  localparam logic [15:0] ABD_START     = 16'h0001;
endpackage

// *** rtl/uabw_sync.sv ***
// three-stage synchroniser for the receive line
`timescale 1ns/100ps
`default_nettype none
module uabw_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;

  always_comb begin
    // a change counts only once the two later stages agree
    next_dout = (s2 == s3) ? s3 : dout;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1   <= 1'b1;
      s2   <= 1'b1;
      s3   <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// *** rtl/uabw_prescale.sv ***
// base clock and measurement clock enable pulses
`timescale 1ns/100ps
`default_nettype none
module uabw_prescale
  import uabw_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic wide_divisor_select,
  input  wire logic high_speed_select,
  output var  logic base_tick,
  output var  logic abd_tick
);
  logic [6:0] pre_cnt;
  logic [3:0] abd_cnt;
  logic [6:0] ratio;
  logic [6:0] next_pre_cnt;
  logic [3:0] next_abd_cnt;
  logic       next_base_tick;
  logic       next_abd_tick;

  always_comb begin
    case ({wide_divisor_select, high_speed_select})
      2'b00:   ratio = PRE_SLOW;
      2'b11:   ratio = PRE_FAST;
      default: ratio = PRE_MID;
    endcase
    next_base_tick = 1'b0;
    next_abd_tick  = 1'b0;
    next_pre_cnt   = pre_cnt + 7'h01;
    next_abd_cnt   = abd_cnt;
    if (next_pre_cnt >= ratio) begin
      next_pre_cnt   = 7'h00;
      next_base_tick = 1'b1;
      next_abd_cnt   = abd_cnt + 4'h1;
      if (next_abd_cnt >= ABD_RATIO) begin
        next_abd_cnt  = 4'h0;
        next_abd_tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt   <= 7'h00;
      abd_cnt   <= 4'h0;
      base_tick <= 1'b0;
      abd_tick  <= 1'b0;
    end else begin
      pre_cnt   <= next_pre_cnt;
      abd_cnt   <= next_abd_cnt;
      base_tick <= next_base_tick;
      abd_tick  <= next_abd_tick;
    end
  end
endmodule
`default_nettype wire

// *** rtl/uabw_top.sv ***
// receiver with auto-baud measurement and wake-on-break, APB registers
//
// Summary of operation
// - receive line gates the rate counter
// - enable starts measurement, receiver held idle
// - count from first rise after start bit
// - fifth rise: keep count, clear enable, flag
// - data read clears flag, value discarded
// - both divisor bytes form one 16-bit counter
// - counter runs at one eighth base clock
// - counter starts at one
// - with wake set, measure the following character
// - overflow sets flag, counting continues
// - overflow clear needs enable already clear
// - wake only in asynchronous mode
// - wake armed: no reception, fall is wake
// - wake sets flag, data read clears it
// - rise ending break clears wake enable
// - non-zero character: first low is wake
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module uabw_top
  import uabw_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        RX_LINE,
  input  wire logic        SLEEP
);
  typedef enum logic [1:0] {AB_OFF, AB_ARM, AB_LOW, AB_COUNT} uabw_ab_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uabw_rx_t;

  logic        receive_line;
  logic        base_tick;
  logic        abd_tick;

  // control and status state
  logic        autobaud_enable;
  logic        wake_on_break_enable;
  logic        wide_divisor_select;
  logic        high_speed_select;
  logic        sync_mode;
  logic        autobaud_overflow_flag;
  logic [15:0] rate_divisor;
  logic        receive_flag;
  logic        frame_error;
  logic [7:0]  receive_data_reg;
  logic        wake_low;
  logic        line_prev;
  uabw_ab_t    ab_state;
  logic [2:0]  rise_cnt;
  uabw_rx_t    rx_state;
  logic [15:0] rx_cnt;
  logic [2:0]  bit_idx;
  logic [7:0]  shift;

  logic        next_autobaud_enable;
  logic        next_wake_on_break_enable;
  logic        next_wide_divisor_select;
  logic        next_high_speed_select;
  logic        next_sync_mode;
  logic        next_autobaud_overflow_flag;
  logic [15:0] next_rate_divisor;
  logic        next_receive_flag;
  logic        next_frame_error;
  logic [7:0]  next_receive_data_reg;
  logic        next_wake_low;
  uabw_ab_t    next_ab_state;
  logic [2:0]  next_rise_cnt;
  uabw_rx_t    next_rx_state;
  logic [15:0] next_rx_cnt;
  logic [2:0]  next_bit_idx;
  logic [7:0]  next_shift;

  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  logic        wr;
  logic        rd;
  logic        mapped;
  logic        fall;
  logic        rise;
  logic        rx_allowed;
  logic [15:0] eff_div;
  logic [16:0] count_sum;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  uabw_sync u_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  (RX_LINE),
    .dout (receive_line)
  );

  uabw_prescale u_pre (
    .clk                 (CLK),
    .rst                 (RST),
    .wide_divisor_select (wide_divisor_select),
    .high_speed_select   (high_speed_select),
    .base_tick           (base_tick),
    .abd_tick            (abd_tick)
  );

  assign wr      = PSEL & PENABLE & PREADY & PWRITE;
  assign rd      = PSEL & PENABLE & PREADY & ~PWRITE;
  assign fall    = line_prev & ~receive_line;
  assign rise    = ~line_prev & receive_line;
  // narrow modes run on the low divisor byte only
  assign eff_div = wide_divisor_select ? rate_divisor
                                       : {8'h00, rate_divisor[7:0]};
  assign mapped  = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STAT)
                || (PADDR == ADDR_DIV) || (PADDR == ADDR_DATA);

  always_comb begin
    ctrl_word                  = 32'h0000_0000;
    ctrl_word[CTRL_AB]         = autobaud_enable;
    ctrl_word[CTRL_WAKE]       = wake_on_break_enable;
    ctrl_word[CTRL_WIDE]       = wide_divisor_select;
    ctrl_word[CTRL_HS]         = high_speed_select;
    ctrl_word[CTRL_SYNC]       = sync_mode;
    ctrl_word[CTRL_OVF]        = autobaud_overflow_flag;
    stat_word                  = 32'h0000_0000;
    stat_word[STAT_FLAG]       = receive_flag;
    stat_word[STAT_IDLE]       = (rx_state == RX_IDLE);
    stat_word[STAT_FERR]       = frame_error;
  end

  // bus answer: data captured in the setup cycle, ready in the access cycle
  always_comb begin
    next_pready  = PSEL & ~PENABLE;
    next_pslverr = PSEL & ~PENABLE & ~mapped;
    next_prdata  = 32'h0000_0000;
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        ADDR_CTRL: next_prdata = ctrl_word;
        ADDR_STAT: next_prdata = stat_word;
        ADDR_DIV:  next_prdata = {16'h0000, rate_divisor};
        ADDR_DATA: next_prdata = {24'h000000, receive_data_reg};
        default:   next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  always_comb begin
    next_autobaud_enable        = autobaud_enable;
    next_wake_on_break_enable   = wake_on_break_enable;
    next_wide_divisor_select    = wide_divisor_select;
    next_high_speed_select      = high_speed_select;
    next_sync_mode              = sync_mode;
    next_autobaud_overflow_flag = autobaud_overflow_flag;
    next_rate_divisor           = rate_divisor;
    next_receive_flag           = receive_flag;
    next_frame_error            = frame_error;
    next_receive_data_reg       = receive_data_reg;
    next_wake_low               = wake_low;
    next_ab_state               = ab_state;
    next_rise_cnt               = rise_cnt;
    next_rx_state               = rx_state;
    next_rx_cnt                 = rx_cnt;
    next_bit_idx                = bit_idx;
    next_shift                  = shift;
    count_sum                   = {1'b0, rate_divisor} + 17'h00001;

    // software side first, so that hardware events below win
    if (wr && PADDR == ADDR_CTRL) begin
      next_autobaud_enable     = PWDATA[CTRL_AB];
      next_wide_divisor_select = PWDATA[CTRL_WIDE];
      next_high_speed_select   = PWDATA[CTRL_HS];
      next_sync_mode           = PWDATA[CTRL_SYNC];
      // wake exists only in asynchronous mode
      next_wake_on_break_enable = PWDATA[CTRL_WAKE]
                                & ~PWDATA[CTRL_SYNC];
      // overflow stays set unless enable was already clear
      next_autobaud_overflow_flag = autobaud_overflow_flag
        & (PWDATA[CTRL_OVF] | autobaud_enable);
    end
    if (wr && PADDR == ADDR_DIV) begin
      next_rate_divisor = PWDATA[15:0];
    end
    if (rd && PADDR == ADDR_DATA) begin
      next_receive_flag = 1'b0;
    end

    // wake-on-break: a fall is the wake event, the next rise ends it
    if (wake_on_break_enable && !sync_mode) begin
      if (fall) begin
        next_receive_flag = 1'b1;
        next_wake_low     = 1'b1;
      end
      if (rise && wake_low) begin
        next_wake_on_break_enable = 1'b0;
        next_wake_low             = 1'b0;
      end
    end else begin
      next_wake_low = 1'b0;
    end

    // auto-baud measurement
    case (ab_state)
      AB_OFF: begin
        // with wake armed, wait for the break to end first
        if (autobaud_enable && !wake_on_break_enable
            && rx_state == RX_IDLE) begin
          next_ab_state = AB_ARM;
        end
      end
      AB_ARM: begin
        if (fall) begin
          next_ab_state = AB_LOW;
        end
      end
      AB_LOW: begin
        if (rise) begin
          next_rate_divisor = ABD_START;
          next_rise_cnt     = 3'h1;
          next_ab_state     = AB_COUNT;
        end
      end
      AB_COUNT: begin
        if (abd_tick) begin
          // the line, not the rate, decides how long this runs
          next_rate_divisor = count_sum[15:0];
          if (count_sum[16]) begin
            next_autobaud_overflow_flag = 1'b1;
          end
        end
        if (rise) begin
          next_rise_cnt = rise_cnt + 3'h1;
          if (next_rise_cnt == SYNC_RISES) begin
            next_autobaud_enable = 1'b0;
            next_receive_flag    = 1'b1;
            next_ab_state        = AB_OFF;
          end
        end
      end
      default: next_ab_state = AB_OFF;
    endcase
    // enable dropped by software mid-measure: stop, no flag
    if (!autobaud_enable && ab_state != AB_OFF) begin
      next_ab_state = AB_OFF;
    end

    // normal reception, mid-bit sampling on the base clock
    if (!rx_allowed) begin
      next_rx_state = RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (fall) begin
            next_rx_cnt   = {1'b0, eff_div[15:1]};
            next_rx_state = RX_START;
          end
        end
        RX_START: begin
          if (base_tick) begin
            if (rx_cnt != 16'h0000) begin
              next_rx_cnt = rx_cnt - 16'h0001;
            end else if (!receive_line) begin
              next_rx_cnt   = eff_div;
              next_bit_idx  = 3'h0;
              next_rx_state = RX_DATA;
            end else begin
              next_rx_state = RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (base_tick) begin
            if (rx_cnt != 16'h0000) begin
              next_rx_cnt = rx_cnt - 16'h0001;
            end else begin
              next_shift   = {receive_line, shift[7:1]};
              next_rx_cnt  = eff_div;
              next_bit_idx = bit_idx + 3'h1;
              if (bit_idx == 3'h7) begin
                next_rx_state = RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (base_tick) begin
            if (rx_cnt != 16'h0000) begin
              next_rx_cnt = rx_cnt - 16'h0001;
            end else begin
              next_receive_data_reg = shift;
              next_frame_error      = ~receive_line;
              next_receive_flag     = 1'b1;
              next_rx_state         = RX_IDLE;
            end
          end
        end
        default: next_rx_state = RX_IDLE;
      endcase
    end
  end

  // no reception while measuring, while wake is armed, or asleep
  assign rx_allowed = ~autobaud_enable & (ab_state == AB_OFF)
                    & ~wake_on_break_enable & ~SLEEP & ~sync_mode;

  always_ff @(posedge CLK) begin
    if (RST) begin
      autobaud_enable        <= 1'b0;
      wake_on_break_enable   <= 1'b0;
      wide_divisor_select    <= 1'b0;
      high_speed_select      <= 1'b0;
      sync_mode              <= 1'b0;
      autobaud_overflow_flag <= 1'b0;
      rate_divisor           <= DIV_RST;
      receive_flag           <= 1'b0;
      frame_error            <= 1'b0;
      receive_data_reg       <= DATA_RST;
      wake_low               <= 1'b0;
      line_prev              <= 1'b1;
      ab_state               <= AB_OFF;
      rise_cnt               <= 3'h0;
      rx_state               <= RX_IDLE;
      rx_cnt                 <= 16'h0000;
      bit_idx                <= 3'h0;
      shift                  <= 8'h00;
    end else begin
      autobaud_enable        <= next_autobaud_enable;
      wake_on_break_enable   <= next_wake_on_break_enable;
      wide_divisor_select    <= next_wide_divisor_select;
      high_speed_select      <= next_high_speed_select;
      sync_mode              <= next_sync_mode;
      autobaud_overflow_flag <= next_autobaud_overflow_flag;
      rate_divisor           <= next_rate_divisor;
      receive_flag           <= next_receive_flag;
      frame_error            <= next_frame_error;
      receive_data_reg       <= next_receive_data_reg;
      wake_low               <= next_wake_low;
      line_prev              <= receive_line;
      ab_state               <= next_ab_state;
      rise_cnt               <= next_rise_cnt;
      rx_state               <= next_rx_state;
      rx_cnt                 <= next_rx_cnt;
      bit_idx                <= next_bit_idx;
      shift                  <= next_shift;
    end
  end
endmodule
`default_nettype wire

// *** dv/uabw_checker.sv ***
// port-level assertions for the auto-baud and wake-on-break block
`timescale 1ns/100ps
`default_nettype none
module uabw_checker
  import uabw_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_LINE,
  input wire logic        SLEEP
);
  logic       rd_ok;
  logic       mapped;
  logic       rx_prev;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic       cleared;
  logic       next_cleared;
  assign rd_ok  = PREADY && !PWRITE;
  assign mapped = PADDR inside {ADDR_CTRL, ADDR_STAT, ADDR_DIV, ADDR_DATA};
  // a data read counts as a clear only once the line has settled, since a
  // hardware set lands a few cycles after each line edge
  always_comb begin
    next_quiet   = quiet + {3'h0, quiet != 4'hf};
    next_cleared = cleared;
    if (rd_ok && PADDR == ADDR_DATA && quiet > 4'h8)
      next_cleared = 1'b1;
    if (RX_LINE != rx_prev) begin
      next_quiet   = 4'h0;
      next_cleared = 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    rx_prev <= RX_LINE;
    if (RST) begin
      quiet   <= 4'h0;
      cleared <= 1'b0;
    end else begin
      quiet   <= next_quiet;
      cleared <= next_cleared;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_single_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ready_in_access: assert property
    (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
    else $error("ready outside access phase");
  a_error_when_unmapped: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error response wrong for address");
  a_error_reads_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("error read returned data");
  a_ctrl_upper_zero: assert property
    (rd_ok && PADDR == ADDR_CTRL |-> PRDATA[31:6] == 26'h0)
    else $error("control read upper bits set");
  a_stat_upper_zero: assert property
    (rd_ok && PADDR == ADDR_STAT |-> PRDATA[31:3] == 29'h0)
    else $error("status read upper bits set");
  a_div_width_sixteen: assert property
    (rd_ok && PADDR == ADDR_DIV |-> PRDATA[31:16] == 16'h0)
    else $error("divisor wider than sixteen bits");
  a_data_upper_zero: assert property
    (rd_ok && PADDR == ADDR_DATA |-> PRDATA[31:8] == 24'h0)
    else $error("data read upper bits set");
  a_flag_read_clear: assert property
    (rd_ok && PADDR == ADDR_STAT && cleared |-> !PRDATA[STAT_FLAG])
    else $error("flag survived data read");
  c_data_read: cover property (rd_ok && PADDR == ADDR_DATA);
  c_error_reply: cover property (PREADY && PSLVERR);
  c_ctrl_write: cover property (PREADY && PWRITE && PADDR == ADDR_CTRL);
  c_flag_seen: cover property (rd_ok && PADDR == ADDR_STAT && PRDATA[0]);
endmodule
bind uabw_top uabw_checker uabw_checker_i (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .RX_LINE(RX_LINE), .SLEEP(SLEEP));
`default_nettype wire

// *** dv/uabw_sender.sv ***
// remote serial sender that drives the receive line
`timescale 1ns/100ps
`default_nettype none
module uabw_sender (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic        brk,
  input  wire logic [7:0]  data,
  input  wire logic [15:0] bit_cyc,
  output var  logic        line,
  output var  logic        busy
);
  logic [13:0] frame;
  int          nbits;
  // line idles high between frames, as the stop level
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        // break is thirteen zero bit times, then stop
        frame = brk ? 14'h2000 : {4'hf, 1'b1, data, 1'b0};
        nbits = brk ? 14 : 10;
        busy <= 1'b1;
        for (int i = 0; i < nbits; i++) begin
          line <= frame[i];
          repeat (bit_cyc) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the auto-baud and wake-on-break block
`timescale 1ns/100ps
`default_nettype none
module tb
  import uabw_pkg::*;
;
  logic        CLK;
  logic        RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        RX_LINE;
  logic        SLEEP;
  logic        go;
  logic        brk;
  logic [7:0]  byte_out;
  logic [15:0] bit_cyc;
  logic        busy;
  int          mismatches;
  int          total_checks;
  int          cycles;
  uabw_top uabw_top_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_LINE(RX_LINE), .SLEEP(SLEEP));
  uabw_sender uabw_sender_i (.clk(CLK), .start(go), .brk(brk),
    .data(byte_out), .bit_cyc(bit_cyc), .line(RX_LINE), .busy(busy));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // longest mode runs near 52k cycles; the whole set stays under 80k
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // the synchroniser delays every edge by 4 cycles, but the tick phase at each end of the window varies, so allow one tick
  task automatic chk_near(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    total_checks++;
    if ($isunknown(got) || got < exp - 1 || got > exp + 1) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] flag(input logic [31:0] v);
    return {31'h0, v[STAT_FLAG]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    r = PRDATA;
    e = PSLVERR;
    if (n >= 50)
      mismatches++;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic send(input logic b, input logic [7:0] v, input int t);
    brk      <= b;
    byte_out <= v;
    bit_cyc  <= t[15:0];
    go       <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 60000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 60000)
      mismatches++;
    repeat (8) @(posedge CLK);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd(ADDR_CTRL, r);
    chk("ctrl reset", 32'h0, r);
    rd(ADDR_DIV, r);
    chk("div reset", {16'h0, DIV_RST}, r);
    rd(ADDR_STAT, r);
    chk("flag reset", 32'h0, flag(r));
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
  endtask
  task automatic t_measure(input logic w, input logic h, input int t,
                           input int per);
    logic [31:0] r;
    logic [31:0] mode;
    mode = {28'h0, h, w, 2'b00};
    wr(ADDR_CTRL, mode | 32'h1);
    send(1'b0, 8'h55, t);
    repeat (3 * t) @(posedge CLK);
    rd(ADDR_STAT, r);
    chk("idle in measure", 32'h2, r & 32'h3);
    wait_idle();
    rd(ADDR_CTRL, r);
    chk("enable cleared", mode, r);
    rd(ADDR_STAT, r);
    chk("flag set", 32'h1, flag(r));
    rd(ADDR_DIV, r);
    chk_near("divisor", 1 + 8 * t / per, r);
    rd(ADDR_DATA, r);
    rd(ADDR_STAT, r);
    chk("flag read clear", 32'h0, flag(r));
  endtask
  task automatic t_abort();
    logic [31:0] r;
    wr(ADDR_CTRL, 32'h0000000d);
    send(1'b0, 8'h55, 128);
    repeat (384) @(posedge CLK);
    wr(ADDR_CTRL, 32'h0000000c);
    wr(ADDR_CTRL, 32'h0000000c);
    rd(ADDR_STAT, r);
    chk("no flag on abort", 32'h0, flag(r));
    rd(ADDR_CTRL, r);
    chk("ctrl after abort", 32'h0000000c, r);
    wait_idle();
    // normal reception resumes mid-frame and may still be busy with the
    // tail of the sync character, so let it finish before moving on
    repeat (256) @(posedge CLK);
    rd(ADDR_DATA, r);
  endtask
  task automatic t_wake();
    logic [31:0] r;
    SLEEP <= 1'b1;
    rd(ADDR_STAT, r);
    chk("idle before arm", 32'h1, {31'h0, r[STAT_IDLE]});
    wr(ADDR_CTRL, 32'h0000000f);
    send(1'b1, 8'h00, 128);
    repeat (256) @(posedge CLK);
    rd(ADDR_STAT, r);
    chk("wake flag", 32'h1, flag(r));
    rd(ADDR_CTRL, r);
    chk("armed in break", 32'h0000000f, r);
    rd(ADDR_DATA, r);
    wait_idle();
    SLEEP <= 1'b0;
    rd(ADDR_CTRL, r);
    chk("wake cleared", 32'h0000000d, r);
    rd(ADDR_STAT, r);
    chk("flag after read", 32'h0, flag(r));
    send(1'b0, 8'h55, 128);
    wait_idle();
    rd(ADDR_DIV, r);
    chk_near("divisor after wake", 32'h21, r);
    rd(ADDR_DATA, r);
  endtask
  task automatic t_misc();
    logic [31:0] r;
    wr(ADDR_CTRL, 32'h00000012);
    send(1'b1, 8'h00, 128);
    wait_idle();
    rd(ADDR_STAT, r);
    chk("no wake in sync", 32'h0, flag(r));
    wr(ADDR_CTRL, 32'h00000002);
    send(1'b0, 8'hf0, 128);
    repeat (300) @(posedge CLK);
    rd(ADDR_STAT, r);
    chk("fragment wake", 32'h1, flag(r));
    wait_idle();
    rd(ADDR_CTRL, r);
    chk("wake off after rise", 32'h0, r);
    rd(ADDR_DATA, r);
  endtask
  initial begin
    RST          = 1'b1;
    PSEL         = 1'b0;
    PENABLE      = 1'b0;
    PWRITE       = 1'b0;
    PADDR        = 8'h00;
    PWDATA       = 32'h0;
    SLEEP        = 1'b0;
    go           = 1'b0;
    brk          = 1'b0;
    byte_out     = 8'h00;
    bit_cyc      = 16'h0001;
    mismatches   = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_measure(1'b0, 1'b0, 1024, 512);
    t_measure(1'b1, 1'b0, 512, 128);
    t_measure(1'b0, 1'b1, 5120, 128);
    t_measure(1'b1, 1'b1, 128, 32);
    t_abort();
    t_wake();
    t_misc();
    complete_run();
  end
endmodule
`default_nettype wire
